// file: testbench/payload_error_inserter_chk.sv
// Port-level assertions for the payload error inserter.
`timescale 1ns/1ns
module payload_error_inserter_chk #(
    parameter int FIFO_DEPTH = 8
) (
    // All ports of the inserter, watched only.
    input wire logic       clk_i, rst_n_i, reg_wr_i,
    input wire logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o,
    input wire logic       t1_mode_i, all_channels_i, tx_valid_i, tx_ready_o, tx_data_i,
    input wire logic       tx_fbit_i, tx_chan_sel_i, line_valid_o, line_ready_i,
    input wire logic       line_data_o, line_fbit_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    // A bit taken into an empty buffer is the next one offered to the line.
    sequence s_take_empty;
        tx_valid_i && tx_ready_o && !line_valid_o;
    endsequence
    sequence s_wr_then_idle;
        reg_wr_i && reg_addr_i == fault_inserter_pkg::ADDR_COUNT_LO ##1
            !reg_wr_i && reg_addr_i == fault_inserter_pkg::ADDR_COUNT_LO;
    endsequence
    a_fbit_untouched: assert property (s_take_empty ##0 tx_fbit_i |=>
        line_valid_o && line_fbit_o && line_data_o == $past(tx_data_i)) else $error("F bit altered");
    a_mode_gate_clean: assert property (s_take_empty ##0 !t1_mode_i |=>
        line_data_o == $past(tx_data_i)) else $error("Bit altered outside T1 mode");
    a_unmarked_clean: assert property (s_take_empty ##0 !all_channels_i && !tx_chan_sel_i |=>
        line_data_o == $past(tx_data_i)) else $error("Unmarked channel bit altered");
    a_line_holds: assert property (line_valid_o && !line_ready_i |=>
        line_valid_o && $stable(line_data_o) && $stable(line_fbit_o)) else $error("Line bit dropped");
    a_unmapped_zero: assert property (reg_addr_i < fault_inserter_pkg::ADDR_RATE_CTRL |=>
        reg_rdata_o == 8'h00) else $error("Unmapped read not zero");
    a_rate_unused: assert property (reg_addr_i == fault_inserter_pkg::ADDR_RATE_CTRL |=>
        reg_rdata_o[6:5] == 2'h0) else $error("Unused rate bits not zero");
    a_high_count_bits: assert property (reg_addr_i inside {8'hed, 8'hef} |=>
        reg_rdata_o[7:2] == 6'h00) else $error("High count bits not zero");
    a_count_readback: assert property (s_wr_then_idle |=>
        reg_rdata_o == $past(reg_wdata_i, 2)) else $error("Count low readback wrong");
    a_empty_ready: assert property (!line_valid_o |-> tx_ready_o) else $error("Empty buffer refused");
endmodule // payload_error_inserter_chk
bind payload_error_inserter payload_error_inserter_chk #(.FIFO_DEPTH(FIFO_DEPTH)) i_payload_error_inserter_chk (.*);

// file: testbench/tb.sv
// Self-checking testbench for the payload error inserter.
`timescale 1ns/1ns
module tb;
    localparam int FL = 25;
    logic       clk_i = 0, rst_n_i = 0, reg_wr_i = 0, t1_mode_i = 1, all_channels_i = 1;
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
    logic       tx_valid_i, tx_ready_o, tx_data_i, tx_fbit_i, tx_chan_sel_i, flip;
    logic       line_valid_o, line_ready_i = 1, line_data_o, line_fbit_o, go = 0, slow = 0, ce = 0;
    logic [3:0] rate = 4'h0, act = 4'h0;
    logic [9:0] left = 10'h000;
    int         bad_count = 0, checks = 0, cyc = 0, takes = 0, pos = 0, cnt = 0;
    payload_error_inserter i_payload_error_inserter (.*);
    tx_formatter_model #(.FRAME_LEN(FL)) i_tx_formatter_model (.clk_i(clk_i), .go_i(go),
        .slow_i(slow), .ready_i(tx_ready_o), .valid_o(tx_valid_i), .data_o(tx_data_i),
        .fbit_o(tx_fbit_i), .sel_o(tx_chan_sel_i));
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Host writes are one-cycle pulses; reads allow one spare edge for pending loads.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1 reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1;
        @(posedge clk_i);
        #1 reg_wr_i = 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        #1 reg_addr_i = a;
        repeat (2) @(posedge clk_i);
        #1 check(reg_rdata_o, exp);
    endtask
    task automatic cfg(input logic c, input logic [3:0] k);
        wr(8'heb, {3'h0, c, k});
        ce = c;
        rate = k;
    endtask
    // Count into both halves first, then the rate with continuous mode clear, then a clean strobe edge.
    task automatic load(input logic [9:0] n);
        wr(8'hec, n[7:0]);
        wr(8'hed, {6'h00, n[9:8]});
        wr(8'heb, {4'h0, rate});
        wr(8'heb, {4'h8, rate});
        left = n;
    endtask
    task automatic run(input int n);
        go = 1;
        repeat (n * FL * 2) @(posedge clk_i);
        #1 go = 0;
        repeat (3 * FL) @(posedge clk_i);
        #1;
    endtask
    // Line-side reference model, sampled mid-cycle where every signal is settled.
    always @(negedge clk_i) begin
        cyc++;
        if (cyc > 20000) begin
            bad_count++;
            test_done();
        end
        if (tx_valid_i && tx_ready_o) takes++;
        if (line_valid_o && line_ready_i) begin
            flip = 0;
            if (line_fbit_o) begin
                pos = 0;
                if (act != rate) cnt = 0;
                act = rate;
            end else if (t1_mode_i && (all_channels_i || pos[0])) begin
                cnt++;
                if (cnt == (8 << act)) begin
                    cnt = 0;
                    flip = act != 0 && (ce || left != 0);
                    if (flip && !ce) left--;
                end
            end
            check({line_fbit_o, line_data_o}, {pos == 0, (pos == 0 || pos[1]) ^ flip});
            pos++;
        end
    end
    initial begin
        repeat (3) @(posedge clk_i);
        #1 rst_n_i = 1;
        repeat (3) @(posedge clk_i);
        for (int a = 8'hea; a <= 8'hef; a++) rd(a[7:0], 8'h00);
        wr(8'hec, 8'ha5);
        wr(8'hed, 8'hff);
        wr(8'hee, 8'h55);
        rd(8'hec, 8'ha5);
        rd(8'hed, 8'h03);
        rd(8'hee, 8'h00);
        $display("Registers test done");
        for (int k = 0; k < 16; k++) begin
            cfg(1, k[3:0]);
            run(k < 3 ? 8 : 2);
        end
        rd(8'hee, 8'h00);
        t1_mode_i = 0;
        cfg(1, 4'h1);
        run(3);
        t1_mode_i = 1;
        all_channels_i = 0;
        slow = 1;
        run(4);
        all_channels_i = 1;
        slow = 0;
        $display("Continuous test done");
        cfg(0, 4'h1);
        load(10'h003);
        rd(8'hee, 8'h03);
        run(4);
        rd(8'hee, 8'h00);
        wr(8'hec, 8'h02);
        wr(8'heb, 8'h81);
        rd(8'hee, 8'h00);
        load(10'h000);
        run(2);
        load(10'h3ff);
        rd(8'hef, 8'h03);
        run(2);
        rd(8'hee, left[7:0]);
        $display("Counted test done");
        cfg(1, 4'h1);
        go = 1;
        @(negedge clk_i iff (tx_valid_i && tx_ready_o && tx_fbit_i));
        repeat (12) @(posedge clk_i);
        cfg(1, 4'h2);
        run(3);
        line_ready_i = 0;
        takes = 0;
        go = 1;
        repeat (12) @(posedge clk_i);
        #1 check(tx_ready_o, 1'b0);
        check(takes[9:0], 10'd8);
        line_ready_i = 1;
        run(1);
        $display("Rate change and buffer test done");
        test_done();
    end
endmodule // tb

// file: testbench/tx_formatter_model.sv
// Behavioural transmit formatter feeding framed bits into the inserter.
`timescale 1ns/1ns
module tx_formatter_model #(
    parameter int FRAME_LEN = 193
) (
    // Clock and pacing controls.
    input  wire logic clk_i,
    input  wire logic go_i,
    input  wire logic slow_i,
    input  wire logic ready_i,
    // Bit stream toward the inserter.
    output      logic valid_o,
    output      logic data_o,
    output      logic fbit_o,
    output      logic sel_o
);
    int   pos   = 0;
    logic taken = 1'b0;
    // A bit stays offered until taken, and frames start only while go_i is high.
    // Idle data is inverted so that nothing downstream can lean on a stale value.
    initial begin
        valid_o = 1'b0;
        data_o = 1'b0;
        fbit_o = 1'b0;
        sel_o = 1'b0;
        forever begin
            @(posedge clk_i);
            taken = valid_o && ready_i;
            #1;
            if (taken) pos = (pos + 1) % FRAME_LEN;
            valid_o = (valid_o && !taken) || ((pos != 0 || go_i) && !(slow_i && taken));
            fbit_o = (pos == 0);
            sel_o = pos[0];
            data_o = valid_o ? ((pos == 0) || pos[1]) : ~data_o;
        end
    end
endmodule // tx_formatter_model

// file: verilog/bit_fifo.sv
// Small valid/ready FIFO used in the transmit data path.
`timescale 1ns/1ns
module bit_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 8
) (
    // Clock and reset.
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    // Fill side.
    input  wire logic             in_valid_i,
    output      logic             in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // Drain side.
    output      logic             out_valid_o,
    input  wire logic             out_ready_i,
    output      logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ff;
    logic [AW-1:0]    nxt_wr;
    logic [AW-1:0]    rd_ff;
    logic [AW-1:0]    nxt_rd;
    logic [AW:0]      cnt_ff;
    logic [AW:0]      nxt_cnt;
    logic             push;
    logic             pop;

    // Honest full and empty come straight from the occupancy count.
    assign in_ready_o  = (cnt_ff != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_ff != '0);
    assign out_data_o  = mem_ff[rd_ff];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // Pointer and count updates; pointers wrap at the depth.
    always_comb begin
        nxt_wr  = wr_ff;
        nxt_rd  = rd_ff;
        nxt_cnt = cnt_ff;
        if (push) begin
            nxt_wr = (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
        end
        if (pop) begin
            nxt_rd = (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
        end
        if (push && !pop) begin
            nxt_cnt = cnt_ff + 1'b1;
        end else if (pop && !push) begin
            nxt_cnt = cnt_ff - 1'b1;
        end
    end

    // Pointer registers.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ff  <= '0;
            rd_ff  <= '0;
            cnt_ff <= '0;
        end else begin
            wr_ff  <= nxt_wr;
            rd_ff  <= nxt_rd;
            cnt_ff <= nxt_cnt;
        end
    end

    // Storage needs no reset since reads are gated by the count.
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_ff[wr_ff] <= in_data_i;
        end
    end

endmodule // bit_fifo

// file: verilog/fault_inserter_pkg.sv
// Constants for the transmit payload error inserter.
//
// Function
// RULE_01: Payload bits are corrupted only while the line runs in T1 mode, on the transmit path.
// RULE_02: Errors go either into every payload channel or only into channels marked for corruption.
// RULE_03: At a rate of one in N the N-th eligible bit of each count of N is inverted.
// RULE_04: Framing bits are never counted and never inverted.
// RULE_05: A newly written rate takes effect only at the next frame boundary.
// RULE_06: Rate code 0 means no insertion and code k means one error per 2^(k+3) bits.
// RULE_07: Continuous mode with a nonzero rate code ignores the count and inserts without end.
// RULE_08: With continuous mode clear only the loaded number of errors is inserted.
// RULE_09: A rising edge of the load strobe copies the count registers into the inserter one clock later; the code copies them two clocks later.
// RULE_10: Only edges of the load strobe act, so the host must write it to 0 and back to 1 to reload.
// RULE_11: The host programs the rate, clears continuous mode, writes the count, then raises the strobe.
// RULE_12: The count is ten bits, low eight in the low register and two upper bits in the high register.
// RULE_13: A loaded count of zero gives no errors and a count of N gives exactly N inverted bits.
// RULE_14: A ten-bit remaining-error value can be read at any time, split like the loaded count.
// RULE_15: The host writes zero to the two unused bits of the rate control register.
// RULE_16: The remaining value drops by one per inverted bit and insertion halts at zero.
package fault_inserter_pkg;

    // Register offsets on the byte-wide host port.
    localparam logic [7:0] ADDR_RATE_CTRL  = 8'heb;
    localparam logic [7:0] ADDR_COUNT_LO   = 8'hec;
    localparam logic [7:0] ADDR_COUNT_HI   = 8'hed;
    localparam logic [7:0] ADDR_LEFT_LO    = 8'hee;
    localparam logic [7:0] ADDR_LEFT_HI    = 8'hef;

    // Field positions in the rate control register.
    localparam int RATE_CODE_LSB    = 0;
    localparam int RATE_CODE_MSB    = 3;
    localparam int CONT_MODE_BIT    = 4;
    localparam int LOAD_STROBE_BIT  = 7;
    localparam logic [7:0] RATE_CTRL_WMASK = 8'h9f;
    localparam logic [1:0] COUNT_HI_MASK   = 2'h3;

    // Reset value of every register.
    localparam logic [7:0] REG_RESET = 8'h00;

    // Count width and rate decode: code k gives a period of 2^(k+RATE_SHIFT).
    localparam int COUNT_W    = 10;
    localparam int RATE_SHIFT = 3;
    localparam int BITCNT_W   = 18;
    localparam logic [3:0] RATE_OFF = 4'h0;

    // Number of reset synchroniser stages.
    localparam int SYNC_STAGES = 2;

endpackage

// file: verilog/payload_error_inserter.sv
// Transmit payload error inserter with its byte-wide register port.
`timescale 1ns/1ns
module payload_error_inserter #(
    parameter int FIFO_DEPTH = 8
) (
    // Clock and reset.
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // Host register port, one access per cycle.
    input  wire logic [7:0] reg_addr_i,
    input  wire logic       reg_wr_i,
    input  wire logic [7:0] reg_wdata_i,
    output      logic [7:0] reg_rdata_o,
    // Line mode from the framer.
    input  wire logic       t1_mode_i,
    input  wire logic       all_channels_i,
    // Transmit bit stream from the formatter.
    input  wire logic       tx_valid_i,
    output      logic       tx_ready_o,
    input  wire logic       tx_data_i,
    input  wire logic       tx_fbit_i,
    input  wire logic       tx_chan_sel_i,
    // Transmit bit stream toward the line.
    output      logic       line_valid_o,
    input  wire logic       line_ready_i,
    output      logic       line_data_o,
    output      logic       line_fbit_o
);
    localparam int CW = fault_inserter_pkg::COUNT_W;
    localparam int BW = fault_inserter_pkg::BITCNT_W;

    // Reset synchroniser.
    logic [fault_inserter_pkg::SYNC_STAGES-1:0] rst_sync_ff;
    logic                                      rst_n;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync_ff <= '0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[fault_inserter_pkg::SYNC_STAGES-2:0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[fault_inserter_pkg::SYNC_STAGES-1];

    // Host registers and inserter state.
    logic [7:0]    rate_ctrl_ff;
    logic [7:0]    nxt_rate_ctrl;
    logic [7:0]    count_lo_ff;
    logic [7:0]    nxt_count_lo;
    logic [1:0]    count_hi_ff;
    logic [1:0]    nxt_count_hi;
    logic          strobe_prev_ff;
    logic          nxt_strobe_prev;
    logic          load_pend_ff;
    logic          nxt_load_pend;
    logic [CW-1:0] left_ff;
    logic [CW-1:0] nxt_left;
    logic [3:0]    active_rate_ff;
    logic [3:0]    nxt_active_rate;
    logic [BW-1:0] bit_cnt_ff;
    logic [BW-1:0] nxt_bit_cnt;
    logic [7:0]    rdata_ff;
    logic [7:0]    nxt_rdata;

    // Stream path signals.
    logic          take;
    logic          eligible;
    logic          last_bit;
    logic          allowed;
    logic          invert;
    logic [BW-1:0] period_m1;
    logic          cont_mode;
    logic          strobe_now;
    logic [1:0]    fifo_in;
    logic [1:0]    fifo_out;
    logic          fifo_ready;

    assign cont_mode  = rate_ctrl_ff[fault_inserter_pkg::CONT_MODE_BIT];
    assign strobe_now = rate_ctrl_ff[fault_inserter_pkg::LOAD_STROBE_BIT];

    // A bit is taken whenever the formatter offers one and the FIFO has room.
    assign tx_ready_o = fifo_ready;
    assign take       = tx_valid_i && fifo_ready;

    // Only T1 payload bits in selected channels are counted.
    assign eligible = t1_mode_i                          // see RULE_01
                      && !tx_fbit_i                      // see RULE_04
                      && (all_channels_i || tx_chan_sel_i); // see RULE_02

    // Period minus one for code k is 2^(k+3)-1; code 0 never inserts.
    // The shift amount is five bits wide, since k+3 reaches 18 and would wrap in four.
    assign period_m1 = (BW'(1) << ({1'b0, active_rate_ff}
                                   + 5'(fault_inserter_pkg::RATE_SHIFT)))
                       - BW'(1); // see RULE_06
    assign last_bit  = (bit_cnt_ff == period_m1); // see RULE_03

    // Continuous mode ignores the count; counted mode needs errors left.
    assign allowed = (active_rate_ff != fault_inserter_pkg::RATE_OFF)    // see RULE_07
                     && (cont_mode || (left_ff != '0));                  // see RULE_08
    assign invert  = take && eligible && last_bit && allowed;

    // Register writes, strobe edge detect and inserter counters.
    always_comb begin
        nxt_rate_ctrl   = rate_ctrl_ff;
        nxt_count_lo    = count_lo_ff;
        nxt_count_hi    = count_hi_ff;
        nxt_strobe_prev = strobe_now;
        nxt_load_pend   = strobe_now && !strobe_prev_ff; // see RULE_09, RULE_10
        nxt_left        = left_ff;
        nxt_active_rate = active_rate_ff;
        nxt_bit_cnt     = bit_cnt_ff;
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                fault_inserter_pkg::ADDR_RATE_CTRL: begin
                    // Unused bits are dropped even if the host sets them.
                    nxt_rate_ctrl = reg_wdata_i & fault_inserter_pkg::RATE_CTRL_WMASK;
                end
                fault_inserter_pkg::ADDR_COUNT_LO: begin
                    nxt_count_lo = reg_wdata_i; // see RULE_12
                end
                fault_inserter_pkg::ADDR_COUNT_HI: begin
                    nxt_count_hi = reg_wdata_i[1:0] & fault_inserter_pkg::COUNT_HI_MASK;
                end
                default: begin
                    nxt_count_lo = count_lo_ff;
                end
            endcase
        end
        // The rate is latched only at a frame bit, so a frame never mixes rates.
        if (take && tx_fbit_i) begin
            nxt_active_rate = rate_ctrl_ff[fault_inserter_pkg::RATE_CODE_MSB:
                                           fault_inserter_pkg::RATE_CODE_LSB]; // see RULE_05
            if (nxt_active_rate != active_rate_ff) begin
                nxt_bit_cnt = '0;
            end
        end else if (take && eligible) begin
            nxt_bit_cnt = last_bit ? '0 : bit_cnt_ff + BW'(1); // see RULE_03
        end
        // A pending load wins over a decrement in the same cycle.
        if (load_pend_ff) begin
            nxt_left = {count_hi_ff, count_lo_ff}; // see RULE_09, RULE_13
        end else if (invert && !cont_mode) begin
            nxt_left = left_ff - CW'(1); // see RULE_16
        end
    end

    // State registers.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rate_ctrl_ff   <= fault_inserter_pkg::REG_RESET;
            count_lo_ff    <= fault_inserter_pkg::REG_RESET;
            count_hi_ff    <= '0;
            strobe_prev_ff <= 1'b0;
            load_pend_ff   <= 1'b0;
            left_ff        <= '0;
            active_rate_ff <= fault_inserter_pkg::RATE_OFF;
            bit_cnt_ff     <= '0;
        end else begin
            rate_ctrl_ff   <= nxt_rate_ctrl;
            count_lo_ff    <= nxt_count_lo;
            count_hi_ff    <= nxt_count_hi;
            strobe_prev_ff <= nxt_strobe_prev;
            load_pend_ff   <= nxt_load_pend;
            left_ff        <= nxt_left;
            active_rate_ff <= nxt_active_rate;
            bit_cnt_ff     <= nxt_bit_cnt;
        end
    end

    // Read data mux; the remaining count is live so it can be read at any time.
    always_comb begin
        unique case (reg_addr_i)
            fault_inserter_pkg::ADDR_RATE_CTRL: nxt_rdata = rate_ctrl_ff;
            fault_inserter_pkg::ADDR_COUNT_LO:  nxt_rdata = count_lo_ff;
            fault_inserter_pkg::ADDR_COUNT_HI:  nxt_rdata = {6'h00, count_hi_ff};
            fault_inserter_pkg::ADDR_LEFT_LO:   nxt_rdata = left_ff[7:0];   // see RULE_14
            fault_inserter_pkg::ADDR_LEFT_HI:   nxt_rdata = {6'h00, left_ff[CW-1:8]};
            default:                            nxt_rdata = 8'h00;
        endcase
    end

    // Read data is registered: valid one cycle after the address.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end
    assign reg_rdata_o = rdata_ff;

    // The corrupted bit and its frame flag are buffered toward the line.
    assign fifo_in = {tx_fbit_i, tx_data_i ^ invert};

    bit_fifo #(
        .WIDTH (2),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n),
        .in_valid_i  (tx_valid_i),
        .in_ready_o  (fifo_ready),
        .in_data_i   (fifo_in),
        .out_valid_o (line_valid_o),
        .out_ready_i (line_ready_i),
        .out_data_o  (fifo_out)
    );

    assign line_data_o = fifo_out[0];
    assign line_fbit_o = fifo_out[1];

endmodule // payload_error_inserter
